/* File: rtl/npx_timing_core.v */
// Escape instruction execution-time model with coprocessor state and APB registers.
//
// Overview of operation
// - Instructions are two bytes, escape prefix first.
// - Counts are coprocessor clocks, transfer time included.
// - Stack index field selects stack element i.
// - Group 011, E3: initialise, 35 clocks.
// - Group 111, E0: store status, 17 clocks.
// - Group 001 reg 101 memory: load control, 23.
// - Group 001 reg 111 memory: store control, 21.
// - Group 011, E2: clear exceptions, 13 clocks.
// - Group 001 reg 110: store environment, 146.
// - Group 001 reg 100: load environment, 113.
// - Group 101 reg 100: restore state, 482.
// - Group 001, F7: stack pointer increment, 23.
// - Group 001, F6: stack pointer decrement, 24.
// - Group 001, E1: absolute value, 24 clocks.
// - Group 001, FD: scale, 69 to 88.
// - Group 001, FC: round integer, 68 to 82.
// - Group 001, F4: split components, 72 to 78.
// - Memory zero load adds 5 clocks.
// - Register subtract adds 3 when d is 0.
// - Integer memory divide adds 1 when reversed.
// - Sine beyond pi/4 adds up to 78.
// - Group 001, FE: sine, 124 to 773.
// - Group 001, F3: partial arctangent, 316 to 489.
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "npx_consts.vh"
module npx_timing_core (
  input wire clk_sys,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output reg busy,
  output reg done,
  output reg [2:0] stack_top,
  output reg [2:0] selected_element
);
  localparam ST_IDLE = 1'b0;
  localparam ST_EXEC = 1'b1;
  localparam [9:0] REDUCE_CAP = `CYC_REDUCE_MAX;

  wire rst_n;
  wire [4:0] op_class;
  wire [9:0] cyc_min;
  wire [9:0] cyc_max;
  wire [2:0] stack_index;
  reg state;
  reg [15:0] opcode;
  reg [15:0] ctrl_word;
  reg [15:0] status_word;
  reg [15:0] env_shadow;
  reg [15:0] host_acc;
  reg [9:0] count;
  reg [9:0] last_cycles;
  reg [4:0] cur_op;
  reg [2:0] cur_index;
  reg operand_zero;
  reg big_operand;
  reg slow_path;
  reg [6:0] reduce_cycles;
  reg unknown;
  reg [9:0] next_total;
  wire apb_wr;
  wire apb_rd;
  wire start;

  npx_sync_reset u_rst (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .rst_n_sync(rst_n)
  );

  npx_decode u_dec (
    .opcode(opcode),
    .op_class(op_class),
    .cyc_min(cyc_min),
    .cyc_max(cyc_max),
    .stack_index(stack_index)
  );

  // The slave always answers in the access cycle; every address is mapped or reads zero.
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign apb_wr = psel && penable && pwrite;
  // Read data is fetched in the setup cycle so that it stands at the access edge.
  assign apb_rd = psel && !penable && !pwrite;
  assign start = apb_wr && (paddr == `ADDR_CTRL) && pwdata[0] && (state == ST_IDLE);

  // Total clocks for the issued instruction, adding operand-dependent extras.
  always @* begin
    next_total = slow_path ? cyc_max : cyc_min;
    case (op_class)
      `OP_LOAD: begin
        if (operand_zero && opcode[9] == 1'b0) begin
          next_total = next_total + `CYC_ZERO;
        end
      end
      `OP_SUBR: begin
        if (opcode[10] == 1'b0) begin
          next_total = next_total + `CYC_SUB_D0;
        end
      end
      `OP_DIVI: begin
        if (opcode[3] == 1'b1) begin
          next_total = next_total + `CYC_DIVI_R;
        end
      end
      `OP_SIN: begin
        if (big_operand) begin
          next_total = next_total + {3'h0, reduce_cycles};
        end
      end
      default: begin
        next_total = next_total;
      end
    endcase
  end

  // Register writes from software; opcode and operand hints are written only while idle.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      opcode <= 16'h0000;
      operand_zero <= 1'b0;
      big_operand <= 1'b0;
      slow_path <= 1'b0;
      reduce_cycles <= 7'h00;
    end else if (apb_wr && state == ST_IDLE) begin
      if (paddr == `ADDR_OPC) begin
        opcode <= pwdata[15:0];
      end
      if (paddr == `ADDR_EXTRA) begin
        operand_zero <= pwdata[0];
        big_operand <= pwdata[1];
        slow_path <= pwdata[2];
        if (pwdata[14:8] > `CYC_REDUCE_MAX) begin
          reduce_cycles <= REDUCE_CAP[6:0];
        end else begin
          reduce_cycles <= pwdata[14:8];
        end
      end
    end
  end

  // Execution sequencer: counts down the modelled clocks, then applies the effect.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      count <= 10'h000;
      last_cycles <= 10'h000;
      cur_op <= `OP_NONE;
      cur_index <= 3'h0;
      busy <= 1'b0;
      done <= 1'b0;
      unknown <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start) begin
            cur_op <= op_class;
            cur_index <= stack_index;
            unknown <= (op_class == `OP_NONE);
            if (op_class == `OP_NONE) begin
              done <= 1'b1;
              last_cycles <= 10'h000;
            end else begin
              count <= next_total;
              last_cycles <= next_total;
              busy <= 1'b1;
              state <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          if (count == 10'h001 || count == 10'h000) begin
            busy <= 1'b0;
            done <= 1'b1;
            state <= ST_IDLE;
          end else begin
            count <= count - 10'h001;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Architectural state, changed when a recognised operation completes; env_shadow also takes control word writes while idle.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_word <= `CW_RESET;
      status_word <= `SW_RESET;
      env_shadow <= 16'h0000;
      host_acc <= 16'h0000;
      stack_top <= 3'h0;
      selected_element <= 3'h0;
    end else begin
      if (apb_wr && paddr == `ADDR_CW && state == ST_IDLE) begin
        env_shadow <= pwdata[15:0];
      end
      if (state == ST_EXEC && (count == 10'h001 || count == 10'h000)) begin
        selected_element <= stack_top + cur_index;
        case (cur_op)
          `OP_INIT: begin
            ctrl_word <= `CW_RESET;
            status_word <= `SW_RESET;
            stack_top <= 3'h0;
          end
          `OP_CLEX: status_word <= {status_word[15:8], 8'h00};
          `OP_STSW: host_acc <= {status_word[15:14], stack_top, status_word[10:0]};
          `OP_LDCW: ctrl_word <= env_shadow;
          `OP_STCW: host_acc <= ctrl_word;
          `OP_STENV: host_acc <= ctrl_word;
          `OP_LDENV: ctrl_word <= env_shadow;
          `OP_RSTOR: begin
            ctrl_word <= env_shadow;
            status_word <= 16'h0000;
          end
          `OP_INCSTP: stack_top <= stack_top + 3'h1;
          `OP_DECSTP: stack_top <= stack_top - 3'h1;
          default: stack_top <= stack_top;
        endcase
      end
    end
  end

  // APB read data, registered in the setup cycle and held through the access phase.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (apb_rd) begin
      case (paddr)
        `ADDR_CTRL: prdata <= {29'h0, unknown, done, busy};
        `ADDR_OPC: prdata <= {16'h0, opcode};
        `ADDR_STAT: prdata <= {19'h0, cur_op, 2'h0, stack_top, selected_element};
        `ADDR_CW: prdata <= {16'h0, ctrl_word};
        `ADDR_SW: prdata <= {host_acc, status_word};
        `ADDR_EXTRA: prdata <= {17'h0, reduce_cycles, 5'h0, slow_path, big_operand,
                                operand_zero};
        `ADDR_CYC: prdata <= {6'h0, count, 6'h0, last_cycles};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
endmodule

/* File: shared/npx_consts.vh */
// Constants for the numeric coprocessor opcode decoder and timing model.
`ifndef NPX_CONSTS_VH
`define NPX_CONSTS_VH
`define ESC_PREFIX 5'h1B
`define GRP_001 3'h1
`define GRP_011 3'h3
`define GRP_101 3'h5
`define GRP_111 3'h7
`define MOD_REG 2'h3
`define REG_LDENV 3'h4
`define REG_LDCW 3'h5
`define REG_STENV 3'h6
`define REG_STCW 3'h7
`define REG_RSTOR 3'h4
`define B_INIT 8'hE3
`define B_CLEX 8'hE2
`define B_STSW 8'hE0
`define B_INCSTP 8'hF7
`define B_DECSTP 8'hF6
`define B_ABS 8'hE1
`define B_SCALE 8'hFD
`define B_RNDINT 8'hFC
`define B_XTRACT 8'hF4
`define B_SIN 8'hFE
`define B_PATAN 8'hF3
`define OP_NONE 5'h00
`define OP_INIT 5'h01
`define OP_STSW 5'h02
`define OP_LDCW 5'h03
`define OP_STCW 5'h04
`define OP_CLEX 5'h05
`define OP_STENV 5'h06
`define OP_LDENV 5'h07
`define OP_RSTOR 5'h08
`define OP_INCSTP 5'h09
`define OP_DECSTP 5'h0A
`define OP_ABS 5'h0B
`define OP_SCALE 5'h0C
`define OP_RNDINT 5'h0D
`define OP_XTRACT 5'h0E
`define OP_SIN 5'h0F
`define OP_PATAN 5'h10
`define OP_SUBR 5'h11
`define OP_DIVI 5'h12
`define OP_LOAD 5'h13
`define CYC_INIT 10'h023
`define CYC_STSW 10'h011
`define CYC_LDCW 10'h017
`define CYC_STCW 10'h015
`define CYC_CLEX 10'h00D
`define CYC_STENV 10'h092
`define CYC_LDENV 10'h071
`define CYC_RSTOR 10'h1E2
`define CYC_INCSTP 10'h017
`define CYC_DECSTP 10'h018
`define CYC_ABS 10'h018
`define CYC_SCALE_MIN 10'h045
`define CYC_SCALE_MAX 10'h058
`define CYC_RND_MIN 10'h044
`define CYC_RND_MAX 10'h052
`define CYC_XTR_MIN 10'h048
`define CYC_XTR_MAX 10'h04E
`define CYC_SIN_MIN 10'h07C
`define CYC_SIN_MAX 10'h305
`define CYC_PAT_MIN 10'h13C
`define CYC_PAT_MAX 10'h1E9
`define CYC_SUB_MIN 10'h01C
`define CYC_SUB_MAX 10'h024
`define CYC_SUB_D0 10'h003
`define CYC_DIVI_MIN 10'h08C
`define CYC_DIVI_MAX 10'h093
`define CYC_DIVI_R 10'h001
`define CYC_LOAD 10'h028
`define CYC_ZERO 10'h005
`define CYC_REDUCE_MAX 10'h04E
`define CW_RESET 16'h037F
`define SW_RESET 16'h0000
`define ADDR_CTRL 12'h000
`define ADDR_OPC 12'h004
`define ADDR_STAT 12'h008
`define ADDR_CW 12'h00C
`define ADDR_SW 12'h010
`define ADDR_EXTRA 12'h014
`define ADDR_CYC 12'h018
`endif

/* File: rtl/npx_sync_reset.v */
// Two-flop release of the asynchronous active-low reset.
`timescale 1ns/1ps
module npx_sync_reset (
  input wire clk_sys,
  input wire nrst,
  output wire rst_n_sync
);
  reg [1:0] stage;

  // Assert at once, release after two clock edges.
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stage <= 2'h0;
    end else begin
      stage <= {stage[0], 1'b1};
    end
  end
  assign rst_n_sync = stage[1];
endmodule

/* File: rtl/npx_decode.v */
// Combinational opcode decoder for two-byte escape-class instructions.
`timescale 1ns/1ps
`include "npx_consts.vh"
module npx_decode (
  input wire [15:0] opcode,
  output reg [4:0] op_class,
  output reg [9:0] cyc_min,
  output reg [9:0] cyc_max,
  output wire [2:0] stack_index
);
  wire [4:0] pfx;
  wire [2:0] grp;
  wire [1:0] modf;
  wire [2:0] regf;
  wire [7:0] b1;
  assign pfx = opcode[15:11];
  assign grp = opcode[10:8];
  assign b1 = opcode[7:0];
  assign modf = opcode[7:6];
  assign regf = opcode[5:3];
  assign stack_index = opcode[2:0];

  // Match the escape prefix, the group and the second byte.
  always @* begin
    op_class = `OP_NONE;
    cyc_min = 10'h000;
    cyc_max = 10'h000;
    if (pfx == `ESC_PREFIX) begin
      if (grp == `GRP_011 && b1 == `B_INIT) begin
        op_class = `OP_INIT;
        cyc_min = `CYC_INIT;
      end else if (grp == `GRP_011 && b1 == `B_CLEX) begin
        op_class = `OP_CLEX;
        cyc_min = `CYC_CLEX;
      end else if (grp == `GRP_111 && b1 == `B_STSW) begin
        op_class = `OP_STSW;
        cyc_min = `CYC_STSW;
      end else if (grp == `GRP_101 && modf != `MOD_REG && regf == `REG_RSTOR) begin
        op_class = `OP_RSTOR;
        cyc_min = `CYC_RSTOR;
      end else if (grp == `GRP_001 && modf != `MOD_REG) begin
        case (regf)
          `REG_LDCW: begin
            op_class = `OP_LDCW;
            cyc_min = `CYC_LDCW;
          end
          `REG_STCW: begin
            op_class = `OP_STCW;
            cyc_min = `CYC_STCW;
          end
          `REG_STENV: begin
            op_class = `OP_STENV;
            cyc_min = `CYC_STENV;
          end
          `REG_LDENV: begin
            op_class = `OP_LDENV;
            cyc_min = `CYC_LDENV;
          end
          default: begin
            op_class = `OP_LOAD;
            cyc_min = `CYC_LOAD;
          end
        endcase
      end else if (grp == `GRP_001) begin
        case (b1)
          `B_INCSTP: begin
            op_class = `OP_INCSTP;
            cyc_min = `CYC_INCSTP;
          end
          `B_DECSTP: begin
            op_class = `OP_DECSTP;
            cyc_min = `CYC_DECSTP;
          end
          `B_ABS: begin
            op_class = `OP_ABS;
            cyc_min = `CYC_ABS;
          end
          `B_SCALE: begin
            op_class = `OP_SCALE;
            cyc_min = `CYC_SCALE_MIN;
            cyc_max = `CYC_SCALE_MAX;
          end
          `B_RNDINT: begin
            op_class = `OP_RNDINT;
            cyc_min = `CYC_RND_MIN;
            cyc_max = `CYC_RND_MAX;
          end
          `B_XTRACT: begin
            op_class = `OP_XTRACT;
            cyc_min = `CYC_XTR_MIN;
            cyc_max = `CYC_XTR_MAX;
          end
          `B_SIN: begin
            op_class = `OP_SIN;
            cyc_min = `CYC_SIN_MIN;
            cyc_max = `CYC_SIN_MAX;
          end
          `B_PATAN: begin
            op_class = `OP_PATAN;
            cyc_min = `CYC_PAT_MIN;
            cyc_max = `CYC_PAT_MAX;
          end
          default: begin
            op_class = `OP_NONE;
          end
        endcase
      end else if (grp[0] == 1'b0 && modf == `MOD_REG && b1[5:4] == 2'h2) begin
        op_class = `OP_SUBR;
        cyc_min = `CYC_SUB_MIN;
        cyc_max = `CYC_SUB_MAX;
      end else if (grp[0] == 1'b0 && grp[2:1] != 2'h0 && modf != `MOD_REG
                   && regf[2:1] == 2'h3) begin
        op_class = `OP_DIVI;
        cyc_min = `CYC_DIVI_MIN;
        cyc_max = `CYC_DIVI_MAX;
      end
    end
    if (cyc_max == 10'h000) begin
      cyc_max = cyc_min;
    end
  end
endmodule

/* File: testbench/npx_timing_core_properties.sv */
// Concurrent checks on the ports of the escape instruction timing model.
`timescale 1ns/1ps
module npx_timing_core_properties (
  input wire clk_sys,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire busy,
  input wire done,
  input wire [2:0] stack_top,
  input wire [2:0] selected_element
);
  logic [15:0] opc_q;
  wire start = psel && penable && pwrite && paddr == 12'h000 && pwdata[0] && !busy;
  // Keeps the instruction word last written while idle, so a start can be tied to it.
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) opc_q <= 16'h0000;
    else if (psel && penable && pwrite && paddr == 12'h004 && !busy) opc_q <= pwdata[15:0];
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Done is registered at edge N after the start, so it is sampled one edge later.
  a_init_time: assert property (start && opc_q == 16'hDBE3 |-> ##36 done)
    else $error("initialise did not end after 35 clocks");
  a_status_time: assert property (start && opc_q == 16'hDFE0 |-> ##18 done)
    else $error("store status did not end after 17 clocks");
  a_clear_time: assert property (start && opc_q == 16'hDBE2 |-> ##14 done)
    else $error("clear exceptions did not end after 13 clocks");
  a_restore_time: assert property (start && opc_q == 16'hDD26 |-> ##[483:483] done)
    else $error("restore state did not end after 482 clocks");
  a_done_single: assert property (done |=> !done)
    else $error("done lasted more than one cycle");
  a_busy_ends_done: assert property ($fell(busy) |-> done)
    else $error("busy fell without done");
  a_busy_min_len: assert property ($rose(busy) |-> busy [*8])
    else $error("operation shorter than the shortest listed time");
  a_busy_bounded: assert property ($rose(busy) |-> ##[1:900] !busy)
    else $error("operation ran past the longest listed time");
  a_stack_at_done: assert property ($changed(stack_top) |-> done)
    else $error("stack pointer moved outside a completion");
  a_select_at_done: assert property ($changed(selected_element) |-> done)
    else $error("selected element moved outside a completion");
  a_bus_no_error: assert property (psel && penable |-> pready && !pslverr)
    else $error("register access stalled or flagged an error");
  c_start: cover property (start);
  c_finish: cover property ($fell(busy));
  c_restore: cover property (start && opc_q == 16'hDD26);
endmodule
bind npx_timing_core npx_timing_core_properties chk (.clk_sys(clk_sys), .nrst(nrst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy), .done(done),
  .stack_top(stack_top), .selected_element(selected_element));

/* File: testbench/host_model.sv */
// Host model that hands escape instructions to the coprocessor over APB.
`timescale 1ns/1ps
`include "npx_consts.vh"
module host_model (
  input wire clk_sys,
  input wire pready,
  input wire [31:0] prdata,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [11:0] paddr = 12'h000,
  output logic [31:0] pwdata = 32'h00000000
);
  // One transfer; the request is held until pready is seen high at an edge.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
  // Read data stands from the setup cycle, so one transfer returns the word.
  task automatic read(input logic [11:0] a, output logic [31:0] r);
    xfer(1'b0, a, 32'h00000000, r);
  endtask
  // Both instruction bytes travel in one word, escape byte in the upper half.
  task automatic issue(input logic [15:0] op, input logic [15:0] ext);
    logic [31:0] r;
    xfer(1'b1, `ADDR_OPC, 32'(op), r);
    xfer(1'b1, `ADDR_EXTRA, 32'(ext), r);
    xfer(1'b1, `ADDR_CTRL, 32'h00000001, r);
  endtask
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench for the escape instruction timing model.
`timescale 1ns/1ps
`include "npx_consts.vh"
module testbench;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, busy, done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] stack_top, selected_element, top0;
  logic [15:0] ext;
  integer err_total = 0, check_count = 0, cyc = 0, t0, i, seed = 32'h4114;
  logic [15:0] ops [0:20] = '{16'hDBE3, 16'hDFE0, 16'hD92E, 16'hD93E, 16'hDBE2, 16'hD936,
    16'hD926, 16'hDD26, 16'hD9F7, 16'hD9F6, 16'hD9E1, 16'hD9FD, 16'hD9FC, 16'hD9F4,
    16'hD9FE, 16'hD9F3, 16'hD906, 16'hDA36, 16'hDA3E, 16'hD8E5, 16'hDCE3};
  always #5 clk_sys = ~clk_sys;
  // Edge counter, also the hang guard.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total = err_total + 1;
      print_verdict();
    end
  end
  npx_timing_core dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy), .done(done), .stack_top(stack_top),
    .selected_element(selected_element));
  host_model host (.clk_sys(clk_sys), .pready(pready), .prdata(prdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  // Expected clocks from the instruction word and the operand hints.
  function automatic logic [9:0] exp_cyc(input logic [15:0] o, input logic [15:0] x);
    logic [9:0] red;
    red = x[1] ? ((x[14:8] > 7'd78) ? 10'd78 : 10'(x[14:8])) : 10'd0;
    case (o)
      16'hDBE3: return 10'd35;
      16'hDFE0: return 10'd17;
      16'hD92E: return 10'd23;
      16'hD93E: return 10'd21;
      16'hDBE2: return 10'd13;
      16'hD936: return 10'd146;
      16'hD926: return 10'd113;
      16'hDD26: return 10'd482;
      16'hD9F7: return 10'd23;
      16'hD9F6: return 10'd24;
      16'hD9E1: return 10'd24;
      16'hD9FD: return x[2] ? 10'd88 : 10'd69;
      16'hD9FC: return x[2] ? 10'd82 : 10'd68;
      16'hD9F4: return x[2] ? 10'd78 : 10'd72;
      16'hD9FE: return (x[2] ? 10'd773 : 10'd124) + red;
      16'hD9F3: return x[2] ? 10'd489 : 10'd316;
      16'hD906: return x[0] ? 10'd45 : 10'd40;
      16'hDA36, 16'hDA3E: return (x[2] ? 10'd147 : 10'd140) + 10'(o[3]);
      default: return (x[2] ? 10'd36 : 10'd28) + (o[10] ? 10'd0 : 10'd3);
    endcase
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Starts one instruction and counts edges from the start edge to done.
  task automatic run_op(input logic [15:0] o, input logic [15:0] x);
    top0 = stack_top;
    host.issue(o, x);
    @(negedge clk_sys);
    t0 = cyc;
    while (done !== 1'b1) @(negedge clk_sys);
    check("cycles", 32'(cyc - t0), 32'(exp_cyc(o, x)));
  endtask
  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Directed table, hint corners, stack effects, unknown words, then random mixes.
  initial begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    host.read(`ADDR_CW, rd);
    check("cw_reset", 32'(rd[15:0]), 32'(`CW_RESET));
    host.xfer(1'b1, `ADDR_CW, 32'h00000A5A, rd);
    for (i = 0; i < 21; i++) run_op(ops[i], 16'h0004);
    for (i = 0; i < 21; i++) run_op(ops[i], 16'h0000);
    host.read(`ADDR_CW, rd);
    check("cw_loaded", 32'(rd[15:0]), 32'h00000A5A);
    run_op(16'hD9FE, 16'h0A02);
    run_op(16'hD9FE, 16'h6402);
    run_op(16'hD906, 16'h0001);
    run_op(16'hD8E5, 16'h0000);
    check("selected", 32'(selected_element), 32'(3'(top0 + 3'd5)));
    run_op(16'hD9F7, 16'h0000);
    check("top_inc", 32'(stack_top), 32'(3'(top0 + 3'd1)));
    run_op(16'hD9F6, 16'h0000);
    check("top_dec", 32'(stack_top), 32'(3'(top0 - 3'd1)));
    top0 = stack_top;
    host.issue(16'hD9D1, 16'h0000);
    host.issue(16'h1234, 16'h0000);
    repeat (4) @(negedge clk_sys);
    check("top_unknown", 32'(stack_top), 32'(top0));
    host.read(`ADDR_CTRL, rd);
    check("unknown_flag", 32'(rd[2:0]), 32'h00000004);
    for (i = 0; i < 12; i++) begin
      ext = 16'($random(seed)) & 16'h0005;
      run_op(ops[{$random(seed)} % 21], ext);
    end
    print_verdict();
  end
endmodule
